//--- shared/tmr_defines.svh
// Register offsets, field positions, reset values and counts of the overflow counter unit.
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_COUNT 8'h00
`define OFF_OPTION 8'h04
`define OFF_INT_CONTROL 8'h08
`define OFF_IRQ_STATUS 8'h0C
`define OFF_IRQ_MASK 8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OPT_CLK_SRC_BIT 5
`define OPT_EDGE_SEL_BIT 4
`define OPT_PRE_ASSIGN_BIT 3
`define OPT_RATE_LSB 0
`define INTC_IRQ_EN_BIT 5
`define INTC_FLAG_BIT 2
`define IRQ_OVF_BIT 0

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define RST_COUNT 8'h00
`define RST_CLK_SRC 1'b1
`define RST_EDGE_SEL 1'b1
`define RST_PRE_ASSIGN 1'b1
`define RST_RATE 3'h7
`define WRITE_INHIBIT_CYCLES 2'h2
`define PHASE_SECOND_QUARTER 2'h1
`define PHASE_FOURTH_QUARTER 2'h3

`endif

//--- shared/tmr_pkg.sv
// Types shared by the overflow counter unit and its phase generator.
`default_nettype none
package tmr_pkg;

   typedef struct packed {
      logic [1:0] phase;
   } phase_state_t;

   typedef struct packed {
      logic [7:0] count;
      logic clk_src;
      logic edge_sel;
      logic pre_off;
      logic [2:0] rate;
      logic flag;
      logic irq_en;
      logic [7:0] pre;
      logic [1:0] inhibit;
      logic pin_meta;
      logic pin_sync;
      logic pin_prev;
      logic pending;
      logic [31:0] prdata;
   } tmr_state_t;

endpackage
`default_nettype wire

//--- hw/quarter_phase_gen.sv
// Quarter phase generator: one instruction cycle is four clock periods.
`include "tmr_defines.svh"
`default_nettype none
module quarter_phase_gen (
   input wire logic pclk, // System clock.
   input wire logic presetn, // Asynchronous reset, active low.
   output logic second_quarter_phase, // Pulse in the second quarter.
   output logic fourth_quarter_phase // Pulse in the last quarter; ends an instruction.
);
   tmr_pkg::phase_state_t s;
   tmr_pkg::phase_state_t next_s;

   always_comb begin
      next_s = s;
      next_s.phase = s.phase + 2'h1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '{phase: 2'h0};
      end else begin
         s <= next_s;
      end
   end

   assign second_quarter_phase = (s.phase == `PHASE_SECOND_QUARTER);
   assign fourth_quarter_phase = (s.phase == `PHASE_FOURTH_QUARTER);
endmodule
`default_nettype wire

//--- hw/overflow_counter_unit.sv
// Eight-bit timer/counter with shared prescaler, overflow flag and APB registers.
//
// Notes on behaviour
// - With the internal source chosen and no prescaler the count rises once per instruction.
// - A software write to the count stops counting for the two instruction cycles after it.
// - Clock source select at one makes the count follow edges of the external pin.
// - Source edge select picks the rising (0) or falling (1) pin edge in counter mode.
// - The prescaler serves this counter only while prescaler assign is zero.
// - The three-bit prescale rate picks one of eight ratios from 1:2 to 1:256.
// - The prescaler is hidden from software and a count write clears it while assigned.
// - Every wrap of the count from FFh to 00h sets the overflow flag, enabled or not.
// - Only software clears the overflow flag; hardware never does.
// - The interrupt output is high only while both flag and enable are set.
// - In sleep the counter is frozen, so no overflow can occur or wake the core.
// - External counts are taken into the count only on second or fourth quarter phases.
`include "tmr_defines.svh"
`default_nettype none
module overflow_counter_unit (
   input wire logic pclk, // System clock, 20 MHz.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pwrite, // APB direction, high for write.
   input wire logic [7:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready, always high.
   output logic pslverr, // APB error for an unmapped address.
   input wire logic external_count_pin, // External count pin, asynchronous.
   input wire logic sleep_mode, // Core is asleep; freezes counting.
   output logic irq // Overflow interrupt, level.
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] prescale_top(input logic [2:0] rate);
      logic [8:0] ratio;
      ratio = 9'h002 << rate;
      return ratio[7:0] - 8'h01;
   endfunction

   function automatic logic addr_mapped(input logic [7:0] a);
      return (a == `OFF_COUNT) || (a == `OFF_OPTION) || (a == `OFF_INT_CONTROL) ||
             (a == `OFF_IRQ_STATUS) || (a == `OFF_IRQ_MASK);
   endfunction

   tmr_pkg::tmr_state_t s;
   tmr_pkg::tmr_state_t next_s;
   logic second_quarter_phase;
   logic fourth_quarter_phase;
   logic acc;
   logic wr;
   logic wr_count;
   logic ext_edge;
   logic src_pulse;
   logic pre_event;
   logic apply;
   logic inc_now;
   logic ovf_set;
   logic flag_clr;

   quarter_phase_gen u_phase (
      .pclk(pclk),
      .presetn(presetn),
      .second_quarter_phase(second_quarter_phase),
      .fourth_quarter_phase(fourth_quarter_phase)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      acc = psel && penable;
      wr = acc && pwrite && addr_mapped(paddr);
      wr_count = wr && (paddr == `OFF_COUNT);

      // Two-stage synchroniser; the edge detector compares the second stage with its delayed copy pin_prev.
      next_s.pin_meta = external_count_pin;
      next_s.pin_sync = s.pin_meta;
      next_s.pin_prev = s.pin_sync;
      ext_edge = s.edge_sel ? (s.pin_prev && !s.pin_sync)
                            : (s.pin_sync && !s.pin_prev);

      // Source selection; sleep removes every source.
      src_pulse = s.clk_src ? ext_edge : fourth_quarter_phase;
      if (sleep_mode) begin
         src_pulse = 1'b0;
      end

      // Prescaler, attached only when assigned.
      pre_event = 1'b0;
      if (!s.pre_off) begin
         if (src_pulse) begin
            if (s.pre == prescale_top(s.rate)) begin
               next_s.pre = 8'h00;
               pre_event = 1'b1;
            end else begin
               next_s.pre = s.pre + 8'h01;
            end
         end
      end else begin
         pre_event = src_pulse;
      end

      // Counter-mode events wait for the next sampling phase so that the count
      // always moves at a known point of the instruction cycle.
      if (s.clk_src) begin
         apply = s.pending && (second_quarter_phase || fourth_quarter_phase)
                 && !sleep_mode;
         next_s.pending = pre_event || (s.pending && !apply);
      end else begin
         apply = pre_event;
         next_s.pending = 1'b0;
      end

      inc_now = apply && (s.inhibit == 2'h0) && !sleep_mode;
      ovf_set = inc_now && (s.count == 8'hFF);
      if (inc_now) begin
         next_s.count = s.count + 8'h01;
      end
      if (fourth_quarter_phase && (s.inhibit != 2'h0)) begin
         next_s.inhibit = s.inhibit - 2'h1;
      end

      // ----------------------------------------------------------------
      // Register writes
      // ----------------------------------------------------------------
      flag_clr = 1'b0;
      if (wr) begin
         case (paddr)
            `OFF_COUNT: begin
               next_s.count = pwdata[7:0];
               next_s.inhibit = `WRITE_INHIBIT_CYCLES;
               next_s.pending = 1'b0;
               if (!s.pre_off) begin
                  next_s.pre = 8'h00;
               end
            end
            `OFF_OPTION: begin
               next_s.clk_src = pwdata[`OPT_CLK_SRC_BIT];
               next_s.edge_sel = pwdata[`OPT_EDGE_SEL_BIT];
               next_s.pre_off = pwdata[`OPT_PRE_ASSIGN_BIT];
               next_s.rate = pwdata[`OPT_RATE_LSB +: 3];
            end
            `OFF_INT_CONTROL: begin
               next_s.irq_en = pwdata[`INTC_IRQ_EN_BIT];
               flag_clr = !pwdata[`INTC_FLAG_BIT];
            end
            `OFF_IRQ_STATUS: begin
               flag_clr = pwdata[`IRQ_OVF_BIT];
            end
            `OFF_IRQ_MASK: begin
               next_s.irq_en = pwdata[`IRQ_OVF_BIT];
            end
            default: begin
               flag_clr = 1'b0;
            end
         endcase
      end
      // A wrap in the same cycle as a clear keeps the flag set.
      next_s.flag = (s.flag && !flag_clr) || ovf_set;

      // ----------------------------------------------------------------
      // Read data, captured in the setup cycle
      // ----------------------------------------------------------------
      if (psel && !penable && !pwrite) begin
         next_s.prdata = 32'h0000_0000;
         case (paddr)
            `OFF_COUNT: begin
               next_s.prdata[7:0] = s.count;
            end
            `OFF_OPTION: begin
               next_s.prdata[`OPT_CLK_SRC_BIT] = s.clk_src;
               next_s.prdata[`OPT_EDGE_SEL_BIT] = s.edge_sel;
               next_s.prdata[`OPT_PRE_ASSIGN_BIT] = s.pre_off;
               next_s.prdata[`OPT_RATE_LSB +: 3] = s.rate;
            end
            `OFF_INT_CONTROL: begin
               next_s.prdata[`INTC_IRQ_EN_BIT] = s.irq_en;
               next_s.prdata[`INTC_FLAG_BIT] = s.flag;
            end
            `OFF_IRQ_STATUS: begin
               next_s.prdata[`IRQ_OVF_BIT] = s.flag;
            end
            `OFF_IRQ_MASK: begin
               next_s.prdata[`IRQ_OVF_BIT] = s.irq_en;
            end
            default: begin
               next_s.prdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '{count: `RST_COUNT, clk_src: `RST_CLK_SRC, edge_sel: `RST_EDGE_SEL,
                pre_off: `RST_PRE_ASSIGN, rate: `RST_RATE, flag: 1'b0, irq_en: 1'b0,
                pre: 8'h00, inhibit: 2'h0, pin_meta: 1'b0, pin_sync: 1'b0,
                pin_prev: 1'b0, pending: 1'b0, prdata: 32'h0000_0000};
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = s.prdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_mapped(paddr);
   assign irq = s.flag && s.irq_en;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence count_write_s;
      psel && penable && pwrite && (paddr == `OFF_COUNT);
   endsequence

   sequence quiet_s;
      !(psel && penable && pwrite);
   endsequence

   sequence status_clear_s;
      psel && penable && pwrite && (paddr == `OFF_IRQ_STATUS) && pwdata[`IRQ_OVF_BIT];
   endsequence

   // The inhibit window is checked only with the bus quiet, since a second count
   // write inside the window legally restarts it.
   write_inhibit_a: assert property (
      count_write_s ##1 (quiet_s [*3]) |-> (s.count == $past(pwdata[7:0], 3))
         || ($past(s.inhibit) == 2'h0))
      else $error("count moved during write inhibit");

   inhibit_arm_a: assert property (
      count_write_s |=> (s.inhibit == 2'h2) && (s.count == $past(pwdata[7:0])))
      else $error("count write did not arm the inhibit");

   timer_step_a: assert property (
      (!s.clk_src && s.pre_off && fourth_quarter_phase && (s.inhibit == 2'h0)
         && !sleep_mode) ##0 quiet_s |=> s.count == $past(s.count) + 8'h01)
      else $error("timer did not step on instruction cycle");

   prescale_clear_a: assert property (
      count_write_s ##0 !s.pre_off |=> s.pre == 8'h00)
      else $error("prescaler not cleared by count write");

   prescale_idle_a: assert property (
      s.pre_off |=> s.pre == $past(s.pre))
      else $error("unassigned prescaler moved");

   wrap_flag_a: assert property (
      inc_now && (s.count == 8'hFF) |=> s.flag && ((s.count == 8'h00) || $past(wr_count)))
      else $error("wrap did not set overflow flag");

   flag_sticky_a: assert property (
      s.flag && !flag_clr |=> s.flag)
      else $error("overflow flag dropped without software");

   soft_clear_a: assert property (
      status_clear_s ##0 !ovf_set |=> !s.flag)
      else $error("status write did not clear overflow flag");

   irq_gate_a: assert property (
      irq == (s.flag && s.irq_en))
      else $error("interrupt not gated by enable");

   sleep_freeze_a: assert property (
      sleep_mode ##0 quiet_s |=> $stable(s.count) && !$rose(s.flag))
      else $error("count moved during sleep");

   edge_pending_a: assert property (
      s.clk_src && s.pre_off && ext_edge && !sleep_mode && !wr_count |=> s.pending)
      else $error("external edge not queued");

   pending_wait_a: assert property (
      s.clk_src && s.pending && !second_quarter_phase && !fourth_quarter_phase && !wr_count
         |=> s.pending)
      else $error("queued count applied outside sampling phase");

   ext_phase_a: assert property (
      s.clk_src ##0 quiet_s ##0 !($past(psel) && $past(penable) && $past(pwrite))
         ##0 (s.count != $past(s.count)) |-> $past(second_quarter_phase)
         || $past(fourth_quarter_phase))
      else $error("external count outside sampling phase");

   ratio_a: assert property (
      !s.pre_off && pre_event |-> s.pre == prescale_top(s.rate))
      else $error("prescaler fired at wrong ratio");

endmodule
`default_nettype wire

//--- dv/eight_bit_timer_counter_bench.sv
// Self-checking bench for the overflow counter unit, driven over APB.
`include "tmr_defines.svh"
`default_nettype none
module eight_bit_timer_counter_bench;
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pin, sleep_mode, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [33:0] notes[$];
   logic [33:0] note;
   logic [7:0] v;
   int num_errors = 0;
   int checked = 0;
   int k;

   always #25 pclk = ~pclk;

   overflow_counter_unit u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_count_pin(pin), .sleep_mode(sleep_mode), .irq(irq)
   );

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      if (num_errors == 0 && checked > 0 && notes.size() == 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // The request stands until pready is seen high; one idle edge follows so that
   // no signal is assigned twice in one time step.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ei,
                     input logic ee = 1'b0);
      notes.push_back({ee, ei, e});
      apb(1'b0, a, 32'h0000_0000);
   endtask

   task automatic pulses(input int n);
      repeat (n) begin
         pin <= 1'b1;
         idle(8);
         pin <= 1'b0;
         idle(8);
      end
   endtask

   // ----------------------------------------------------------------
   // Result watcher
   // ----------------------------------------------------------------
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0
          && notes.size() > 0) begin
         note = notes.pop_front();
         check("prdata", prdata, note[31:0]);
         check("irq", {31'h0000_0000, irq}, {31'h0000_0000, note[32]});
         check("pslverr", {31'h0000_0000, pslverr}, {31'h0000_0000, note[33]});
      end
   end

   initial begin
      idle(20000);
      num_errors++;
      conclude();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      presetn <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h0000_0000;
      pin <= 1'b0;
      sleep_mode <= 1'b0;
      void'($urandom(93));
      idle(20);
      presetn <= 1'b1;
      idle(1);
      rd(`OFF_COUNT, 32'h0000_0000, 1'b0);
      rd(`OFF_OPTION, 32'h0000_003F, 1'b0);
      rd(`OFF_INT_CONTROL, 32'h0000_0000, 1'b0);
      rd(`OFF_IRQ_MASK, 32'h0000_0000, 1'b0);
      rd(8'h14, 32'h0000_0000, 1'b0, 1'b1);
      // Counter mode, rising edge: four rises and three falls.
      apb(1'b1, `OFF_OPTION, 32'h0000_0028);
      apb(1'b1, `OFF_COUNT, 32'h0000_0000);
      idle(16);
      pulses(3);
      pin <= 1'b1;
      idle(16);
      rd(`OFF_COUNT, 32'h0000_0004, 1'b0);
      // Falling edge: three falls and two rises.
      apb(1'b1, `OFF_OPTION, 32'h0000_0038);
      apb(1'b1, `OFF_COUNT, 32'h0000_0000);
      idle(16);
      pin <= 1'b0;
      idle(8);
      pulses(2);
      idle(8);
      rd(`OFF_COUNT, 32'h0000_0003, 1'b0);
      // Timer mode: the 4k edges after the write hold exactly k ticks, two of them lost to the inhibit.
      apb(1'b1, `OFF_OPTION, 32'h0000_0008);
      v = 8'($urandom_range(0, 255));
      k = $urandom_range(3, 40);
      apb(1'b1, `OFF_COUNT, {24'h00_0000, v});
      idle(4 * k - 1);
      rd(`OFF_COUNT, {24'h00_0000, 8'(v + k - 2)}, 1'b0);
      // Prescaler rates; the write clears it, k mod ratio keeps the read off a prescaler event edge.
      for (int r = 1; r < 8; r++) begin
         apb(1'b1, `OFF_OPTION, r);
         apb(1'b1, `OFF_COUNT, 32'h0000_0000);
         k = (2 << (r + 1)) + (1 << r) + 1;
         idle(4 * k - 1);
         rd(`OFF_COUNT, 32'h0000_0002, 1'b0);
      end
      // Sleep freezes the count.
      apb(1'b1, `OFF_OPTION, 32'h0000_0008);
      sleep_mode <= 1'b1;
      apb(1'b1, `OFF_COUNT, 32'h0000_0010);
      idle(39);
      rd(`OFF_COUNT, 32'h0000_0010, 1'b0);
      sleep_mode <= 1'b0;
      // Overflow with the interrupt masked, then enabled, then cleared.
      apb(1'b1, `OFF_IRQ_STATUS, 32'h0000_0001);
      apb(1'b1, `OFF_COUNT, 32'h0000_00FE);
      idle(19);
      rd(`OFF_COUNT, 32'h0000_0001, 1'b0);
      apb(1'b1, `OFF_OPTION, 32'h0000_0028);
      rd(`OFF_INT_CONTROL, 32'h0000_0004, 1'b0);
      apb(1'b1, `OFF_INT_CONTROL, 32'h0000_0024);
      idle(100);
      rd(`OFF_IRQ_STATUS, 32'h0000_0001, 1'b1);
      apb(1'b1, `OFF_INT_CONTROL, 32'h0000_0020);
      rd(`OFF_INT_CONTROL, 32'h0000_0020, 1'b0);
      // Second overflow from the pin, cleared through the status register.
      apb(1'b1, `OFF_COUNT, 32'h0000_00FF);
      idle(16);
      pulses(1);
      rd(`OFF_IRQ_STATUS, 32'h0000_0001, 1'b1);
      apb(1'b1, `OFF_IRQ_STATUS, 32'h0000_0001);
      rd(`OFF_IRQ_MASK, 32'h0000_0001, 1'b0);
      idle(4);
      conclude();
   end
endmodule
`default_nettype wire
